// *** ccs_pkg.sv ***
// Purpose: Shared constants for the clock source configuration block.
// Assumes: A serial control port with a 16-bit instruction and one data byte.
// Notes: Offsets are byte addresses on the serial control port.
package ccs_pkg;
	// Serial frame layout.
	localparam int unsigned ADDR_W = 13; // Address field width.
	localparam int unsigned DATA_W = 8; // Register width.
	localparam logic [4:0] INSTR_LAST_BIT = 5'h0f; // Count at the last instruction bit.
	localparam logic [4:0] FRAME_LAST_BIT = 5'h17; // Count at the last data bit.
	localparam int unsigned RW_BIT = 15; // Read flag position within the instruction.
	// Register offsets.
	localparam logic [12:0] OFS_PLL = 13'h0010; // PLL power mode and polarity.
	localparam logic [12:0] OFS_CAL = 13'h0018; // Oscillator calibration control.
	localparam logic [12:0] OFS_REF = 13'h001c; // Reference input enables.
	localparam logic [12:0] OFS_DIV = 13'h01e0; // Oscillator divider setting.
	localparam logic [12:0] OFS_ROUTE = 13'h01e1; // Input routing select.
	localparam logic [12:0] OFS_UPDATE = 13'h0232; // Register update trigger.
	localparam logic [12:0] OFS_NVM_CTRL = 13'h0b00; // Store request.
	localparam logic [12:0] OFS_STATUS = 13'h0b01; // Block status.
	// Field positions.
	localparam int unsigned PLL_MODE_LSB = 0; // Two-bit power mode field.
	localparam logic [1:0] PLL_MODE_RUN = 2'h0; // Normal running.
	localparam int unsigned CAL_BIT = 0; // Calibration request bit.
	localparam int unsigned UPDATE_BIT = 0; // Update strobe bit.
	localparam int unsigned SAVE_BIT = 0; // Store request bit.
	localparam int unsigned BYPASS_BIT = 0; // Divider bypass bit.
	localparam int unsigned OSC_SEL_BIT = 1; // Oscillator source select bit.
	// Reset values.
	localparam logic [7:0] RST_PLL = 8'h01; // Asynchronous power-down.
	localparam logic [7:0] RST_CAL = 8'h00;
	localparam logic [7:0] RST_REF = 8'h00;
	localparam logic [7:0] RST_DIV = 8'h00; // Divide by two.
	localparam logic [7:0] RST_ROUTE = 8'h00; // Divider in use, external input.
	// Nonvolatile store layout: entry 0 is a validity marker, entries 1 to 5 the registers.
	localparam int unsigned NVM_AW = 3;
	localparam logic [2:0] NVM_IDX_MARK = 3'h0;
	localparam logic [2:0] NVM_IDX_PLL = 3'h1;
	localparam logic [2:0] NVM_IDX_CAL = 3'h2;
	localparam logic [2:0] NVM_IDX_REF = 3'h3;
	localparam logic [2:0] NVM_IDX_DIV = 3'h4;
	localparam logic [2:0] NVM_IDX_ROUTE = 3'h5;
	localparam logic [7:0] NVM_MARKER = 8'ha5; // Marks a stored image as valid.
	// Timing.
	localparam int unsigned CLK_PERIOD_NS = 100; // System clock period.
	localparam int unsigned CAL_TIME_NS = 100000; // Calibration duration.
	localparam int unsigned CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Controller states.
	typedef enum logic [4:0] {
		ST_WAIT = 5'h01,
		ST_CHECK = 5'h02,
		ST_LOAD_ADDR = 5'h04,
		ST_LOAD_TAKE = 5'h08,
		ST_IDLE = 5'h10
	} ccs_state_t;
endpackage

// *** ccs_mem_if.sv ***
// Purpose: Carries the store port between the controller and the store.
// Assumes: One write port and one registered read port.
// Notes: The read address is sampled every cycle.
`timescale 1ns/100ps
interface ccs_mem_if #(
	parameter int unsigned AW = 3,
	parameter int unsigned DW = 8
);
	logic we; // Write strobe.
	logic [AW-1:0] waddr; // Write address.
	logic [DW-1:0] wdata; // Write data.
	logic [AW-1:0] raddr; // Read address.
	logic [DW-1:0] rdata; // Read data, one cycle after the address.
	modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
	modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** ccs_nvm.sv ***
// Purpose: Small store that keeps the saved configuration image.
// Assumes: Contents are not touched by reset so they survive it.
// Notes: Read data come out of a register.
`timescale 1ns/100ps
module ccs_nvm #(
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk_sys_i,
	ccs_mem_if.mem port
);
	logic [7:0] mem_q [DEPTH]; // Storage cells, kept across reset.

	// Writes land in the array; reads are registered.
	always_ff @(posedge clk_sys_i) begin
		if (port.we) begin
			mem_q[port.waddr] <= port.wdata;
		end
		port.rdata <= mem_q[port.raddr];
	end
endmodule

// *** ccs_top.sv ***
// Purpose: Configuration logic of a clock source with oscillator, PLL and divider.
// Assumes: Serial clock runs at most a quarter of clk_sys_i; pins are asynchronous.
// Notes: Writes go to shadow registers and take effect on the update strobe.
// What this block does
// - PLL runs when power mode is zero.
// - Source bit one selects internal oscillator.
// - Bypass bit zero feeds from oscillator divider.
// - Zero then update discards earlier calibration.
// - One then update starts a calibration when the active bit was zero.
// - Settings saved to store, reloaded at power-up.
// - Reset gives PLL off, divide by two.
// - Bypass bit one skips the divider.
// - Source bit zero selects external input.
`timescale 1ns/100ps
module ccs_top (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic spi_sclk_i,
	input wire logic spi_csn_i,
	input wire logic spi_sdi_i,
	output logic spi_sdo_o,
	output logic spi_sdo_oe_o,
	output logic [7:0] pll_ctrl_o,
	output logic pll_run_o,
	output logic [2:0] ref_en_o,
	output logic [2:0] osc_div_o,
	output logic osc_sel_o,
	output logic div_bypass_o,
	output logic cal_start_o,
	output logic cal_busy_o,
	output logic nvm_busy_o
);
	// Synchronisers for the serial pins; stage one feeds stage two only.
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic csn_s1_q, csn_s2_q;
	logic sdi_s1_q, sdi_s2_q;
	logic sclk_rise, sclk_fall; // Serial clock edges seen in the system domain.
	// Serial engine state.
	logic [4:0] bit_cnt_q; // Bits received in the current frame.
	logic [22:0] rx_q; // Received bits so far.
	logic [12:0] addr_q; // Captured register address.
	logic rd_q; // Frame is a read.
	logic [7:0] tx_q; // Read data being shifted out.
	logic wr_stb; // One-cycle write pulse at the last data bit.
	logic [7:0] wr_data; // Data byte of that write.
	// Shadow and active registers.
	logic [7:0] sh_pll_q, sh_cal_q, sh_ref_q, sh_div_q, sh_route_q;
	logic [7:0] ac_pll_q, ac_cal_q, ac_ref_q, ac_div_q, ac_route_q;
	logic upd_q; // Pending update strobe.
	logic save_q; // Pending store request.
	localparam int unsigned CAL_CYCLES_L = ccs_pkg::CAL_CYCLES; // Calibration length in cycles.
	logic [$clog2(CAL_CYCLES_L + 1)-1:0] cal_cnt_q; // Remaining calibration cycles.
	// Store controller.
	ccs_pkg::ccs_state_t state_q;
	logic [2:0] idx_q; // Store entry in use.
	logic saving_q; // Store write sequence in progress.
	ccs_mem_if #(.AW(ccs_pkg::NVM_AW), .DW(ccs_pkg::DATA_W)) mem_if ();

	// Returns the active value that belongs in a store entry.
	function automatic logic [7:0] entry_val(input logic [2:0] idx);
		unique case (idx)
			ccs_pkg::NVM_IDX_PLL: entry_val = ac_pll_q;
			ccs_pkg::NVM_IDX_CAL: entry_val = ac_cal_q;
			ccs_pkg::NVM_IDX_REF: entry_val = ac_ref_q;
			ccs_pkg::NVM_IDX_DIV: entry_val = ac_div_q;
			ccs_pkg::NVM_IDX_ROUTE: entry_val = ac_route_q;
			default: entry_val = ccs_pkg::NVM_MARKER;
		endcase
	endfunction

	// Returns the read-back value at a register address; unmapped reads give zero.
	function automatic logic [7:0] read_val(input logic [12:0] a);
		unique case (a)
			ccs_pkg::OFS_PLL: read_val = sh_pll_q;
			ccs_pkg::OFS_CAL: read_val = sh_cal_q;
			ccs_pkg::OFS_REF: read_val = sh_ref_q;
			ccs_pkg::OFS_DIV: read_val = sh_div_q;
			ccs_pkg::OFS_ROUTE: read_val = sh_route_q;
			ccs_pkg::OFS_UPDATE: read_val = {7'h00, upd_q};
			ccs_pkg::OFS_NVM_CTRL: read_val = {7'h00, save_q};
			ccs_pkg::OFS_STATUS: read_val = {6'h00, nvm_busy_o, cal_busy_o};
			default: read_val = 8'h00;
		endcase
	endfunction

	// Two-flop synchronisers, plus a third sclk stage for edge detection.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			csn_s1_q <= 1'b1;
			csn_s2_q <= 1'b1;
			sdi_s1_q <= 1'b0;
			sdi_s2_q <= 1'b0;
		end else begin
			sclk_s1_q <= spi_sclk_i;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			csn_s1_q <= spi_csn_i;
			csn_s2_q <= csn_s1_q;
			sdi_s1_q <= spi_sdi_i;
			sdi_s2_q <= sdi_s1_q;
		end
	end

	assign sclk_rise = sclk_s2_q & ~sclk_s3_q & ~csn_s2_q;
	assign sclk_fall = ~sclk_s2_q & sclk_s3_q & ~csn_s2_q;
	// A write completes on the rise that brings in the last data bit.
	assign wr_stb = sclk_rise & ~rd_q & (bit_cnt_q == ccs_pkg::FRAME_LAST_BIT);
	assign wr_data = {rx_q[6:0], sdi_s2_q};

	// Serial engine: bits in on rising sclk, read data out on falling sclk.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt_q <= 5'h00;
			rx_q <= 23'h000000;
			addr_q <= 13'h0000;
			rd_q <= 1'b0;
			tx_q <= 8'h00;
			spi_sdo_o <= 1'b0;
			spi_sdo_oe_o <= 1'b0;
		end else if (csn_s2_q) begin
			// Chip select high ends the frame and releases the data line.
			bit_cnt_q <= 5'h00;
			rd_q <= 1'b0;
			spi_sdo_oe_o <= 1'b0;
		end else begin
			if (sclk_rise) begin
				rx_q <= {rx_q[21:0], sdi_s2_q};
				if (bit_cnt_q != ccs_pkg::FRAME_LAST_BIT) begin
					bit_cnt_q <= bit_cnt_q + 5'h01;
				end
				if (bit_cnt_q == ccs_pkg::INSTR_LAST_BIT) begin
					// Instruction complete: latch address and direction.
					addr_q <= {rx_q[11:0], sdi_s2_q};
					rd_q <= rx_q[ccs_pkg::RW_BIT - 1];
					tx_q <= read_val({rx_q[11:0], sdi_s2_q});
				end
			end
			if (sclk_fall && rd_q) begin
				// Present the next read bit, most significant first.
				spi_sdo_o <= tx_q[7];
				spi_sdo_oe_o <= 1'b1;
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	// Shadow registers take serial writes, or the stored image at power-up.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sh_pll_q <= ccs_pkg::RST_PLL;
			sh_cal_q <= ccs_pkg::RST_CAL;
			sh_ref_q <= ccs_pkg::RST_REF;
			sh_div_q <= ccs_pkg::RST_DIV;
			sh_route_q <= ccs_pkg::RST_ROUTE;
		end else if (state_q == ccs_pkg::ST_LOAD_TAKE) begin
			// Reload from the store without software action.
			unique case (idx_q)
				ccs_pkg::NVM_IDX_PLL: sh_pll_q <= mem_if.rdata;
				ccs_pkg::NVM_IDX_CAL: sh_cal_q <= mem_if.rdata;
				ccs_pkg::NVM_IDX_REF: sh_ref_q <= mem_if.rdata;
				ccs_pkg::NVM_IDX_DIV: sh_div_q <= mem_if.rdata;
				default: sh_route_q <= mem_if.rdata;
			endcase
		end else if (wr_stb) begin
			// Each register is written on its own.
			unique case (addr_q)
				ccs_pkg::OFS_PLL: sh_pll_q <= wr_data;
				ccs_pkg::OFS_CAL: sh_cal_q <= wr_data;
				ccs_pkg::OFS_REF: sh_ref_q <= wr_data;
				ccs_pkg::OFS_DIV: sh_div_q <= wr_data;
				ccs_pkg::OFS_ROUTE: sh_route_q <= wr_data;
				default: ;
			endcase
		end
	end

	// Update and store requests; a new request wins over the clearing cycle.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			upd_q <= 1'b0;
			save_q <= 1'b0;
		end else begin
			if (wr_stb && addr_q == ccs_pkg::OFS_UPDATE && wr_data[ccs_pkg::UPDATE_BIT]) begin
				upd_q <= 1'b1;
			end else begin
				upd_q <= 1'b0; // Strobe clears itself once applied.
			end
			if (wr_stb && addr_q == ccs_pkg::OFS_NVM_CTRL && wr_data[ccs_pkg::SAVE_BIT]) begin
				save_q <= 1'b1;
			end else if (state_q == ccs_pkg::ST_IDLE && !saving_q) begin
				save_q <= 1'b0;
			end
		end
	end

	// Active registers copy the shadow set on the update strobe.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ac_pll_q <= ccs_pkg::RST_PLL;
			ac_cal_q <= ccs_pkg::RST_CAL;
			ac_ref_q <= ccs_pkg::RST_REF;
			ac_div_q <= ccs_pkg::RST_DIV;
			ac_route_q <= ccs_pkg::RST_ROUTE;
		end else if (state_q == ccs_pkg::ST_LOAD_TAKE) begin
			// Stored values act at once after power-up.
			unique case (idx_q)
				ccs_pkg::NVM_IDX_PLL: ac_pll_q <= mem_if.rdata;
				ccs_pkg::NVM_IDX_CAL: ac_cal_q <= mem_if.rdata;
				ccs_pkg::NVM_IDX_REF: ac_ref_q <= mem_if.rdata;
				ccs_pkg::NVM_IDX_DIV: ac_div_q <= mem_if.rdata;
				default: ac_route_q <= mem_if.rdata;
			endcase
		end else if (upd_q) begin
			ac_pll_q <= sh_pll_q;
			ac_cal_q <= sh_cal_q; // A zero here discards the prior request.
			ac_ref_q <= sh_ref_q;
			ac_div_q <= sh_div_q;
			ac_route_q <= sh_route_q;
		end
	end

	// Calibration runs only on a fresh zero-to-one of the active bit.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cal_start_o <= 1'b0;
			cal_busy_o <= 1'b0;
			cal_cnt_q <= '0;
		end else if (upd_q && sh_cal_q[ccs_pkg::CAL_BIT] && !ac_cal_q[ccs_pkg::CAL_BIT]) begin
			cal_start_o <= 1'b1;
			cal_busy_o <= 1'b1;
			cal_cnt_q <= ($bits(cal_cnt_q))'(CAL_CYCLES_L - 1);
		end else if (upd_q && !sh_cal_q[ccs_pkg::CAL_BIT]) begin
			cal_start_o <= 1'b0; // Clearing stops any calibration in progress.
			cal_busy_o <= 1'b0;
			cal_cnt_q <= '0;
		end else begin
			cal_start_o <= 1'b0;
			if (cal_cnt_q != '0) begin
				cal_cnt_q <= cal_cnt_q - 1'b1;
			end else begin
				cal_busy_o <= 1'b0;
			end
		end
	end

	// Drive the analogue controls from the active registers.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pll_ctrl_o <= ccs_pkg::RST_PLL;
			pll_run_o <= 1'b0;
			ref_en_o <= 3'h0;
			osc_div_o <= 3'h0;
			osc_sel_o <= 1'b0;
			div_bypass_o <= 1'b0;
		end else begin
			pll_ctrl_o <= ac_pll_q;
			pll_run_o <= (ac_pll_q[ccs_pkg::PLL_MODE_LSB +: 2] == ccs_pkg::PLL_MODE_RUN);
			ref_en_o <= ac_ref_q[2:0];
			osc_div_o <= ac_div_q[2:0];
			osc_sel_o <= ac_route_q[ccs_pkg::OSC_SEL_BIT];
			div_bypass_o <= ac_route_q[ccs_pkg::BYPASS_BIT];
		end
	end

	// Store controller: reload after reset, then save on request.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ccs_pkg::ST_WAIT;
			idx_q <= ccs_pkg::NVM_IDX_MARK;
			saving_q <= 1'b0;
			nvm_busy_o <= 1'b1;
		end else begin
			unique case (state_q)
				ccs_pkg::ST_WAIT: state_q <= ccs_pkg::ST_CHECK;
				ccs_pkg::ST_CHECK: begin
					// A missing marker leaves the reset values in place.
					if (mem_if.rdata == ccs_pkg::NVM_MARKER) begin
						idx_q <= ccs_pkg::NVM_IDX_PLL;
						state_q <= ccs_pkg::ST_LOAD_ADDR;
					end else begin
						state_q <= ccs_pkg::ST_IDLE;
						nvm_busy_o <= 1'b0;
					end
				end
				ccs_pkg::ST_LOAD_ADDR: state_q <= ccs_pkg::ST_LOAD_TAKE;
				ccs_pkg::ST_LOAD_TAKE: begin
					if (idx_q == ccs_pkg::NVM_IDX_ROUTE) begin
						state_q <= ccs_pkg::ST_IDLE;
						nvm_busy_o <= 1'b0;
					end else begin
						idx_q <= idx_q + 3'h1;
						state_q <= ccs_pkg::ST_LOAD_ADDR;
					end
				end
				ccs_pkg::ST_IDLE: begin
					// Save entries 1 to 5, then the marker, one per cycle.
					if (saving_q) begin
						if (idx_q == ccs_pkg::NVM_IDX_MARK) begin
							saving_q <= 1'b0;
							nvm_busy_o <= 1'b0;
						end else if (idx_q == ccs_pkg::NVM_IDX_ROUTE) begin
							idx_q <= ccs_pkg::NVM_IDX_MARK;
						end else begin
							idx_q <= idx_q + 3'h1;
						end
					end else if (save_q) begin
						saving_q <= 1'b1;
						nvm_busy_o <= 1'b1;
						idx_q <= ccs_pkg::NVM_IDX_PLL;
					end
				end
				default: state_q <= ccs_pkg::ST_IDLE;
			endcase
		end
	end

	assign mem_if.raddr = idx_q;
	assign mem_if.we = saving_q;
	assign mem_if.waddr = idx_q;
	assign mem_if.wdata = entry_val(idx_q);

	// Store that holds the saved image across reset.
	ccs_nvm #(.DEPTH(8)) u_nvm (
		.clk_sys_i(clk_sys_i),
		.port(mem_if.mem)
	);
endmodule

// *** ccs_top_sva.sv ***
// Purpose: Concurrent checks on the ports of the clock source configuration block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound into every instance of the top module.
`timescale 1ns/100ps
module ccs_top_sva (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic spi_csn_i,
	input wire logic spi_sdo_oe_o,
	input wire logic [7:0] pll_ctrl_o,
	input wire logic pll_run_o,
	input wire logic [2:0] ref_en_o,
	input wire logic [2:0] osc_div_o,
	input wire logic osc_sel_o,
	input wire logic div_bypass_o,
	input wire logic cal_start_o,
	input wire logic cal_busy_o,
	input wire logic nvm_busy_o
);
	// One cycle of slack covers the registered busy level.
	localparam int unsigned CAL_MAX = ccs_pkg::CAL_CYCLES + 1;
	logic [10:0] busy_cnt_q; // Cycles the calibration level has stood so far.

	// Counts how long the busy level stands, so a stuck level is caught.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_cnt_q <= 11'h000;
		end else begin
			busy_cnt_q <= cal_busy_o ? busy_cnt_q + 11'h001 : 11'h000;
		end
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	// Chip select seen high long enough for the synchroniser.
	sequence csn_idle;
		spi_csn_i [*4];
	endsequence
	// No serial traffic and no store activity for a while.
	sequence cfg_quiet;
		(spi_csn_i && !nvm_busy_o) [*8];
	endsequence
	// A start pulse that lasts exactly one cycle.
	sequence cal_kick;
		cal_start_o ##1 !cal_start_o;
	endsequence

	chk_run_mode: assert property (
		pll_run_o == (pll_ctrl_o[1:0] == ccs_pkg::PLL_MODE_RUN))
		else $error("pll run level disagrees with power mode field");
	chk_reset_defaults: assert property (
		$rose(resetn_i) |-> pll_ctrl_o == ccs_pkg::RST_PLL && osc_div_o == 3'h0 &&
		!osc_sel_o && !div_bypass_o)
		else $error("outputs not at defaults after reset");
	chk_cal_pulse: assert property (cal_start_o |-> cal_kick)
		else $error("calibration start is not a single pulse");
	chk_cal_busy: assert property (cal_start_o |-> ##[0:1] cal_busy_o)
		else $error("calibration busy did not follow start");
	chk_cal_length: assert property (busy_cnt_q <= CAL_MAX)
		else $error("calibration busy stood too long");
	chk_start_idle: assert property (cal_start_o |-> !$past(cal_busy_o))
		else $error("calibration restarted while running");
	chk_oe_release: assert property (csn_idle |-> !spi_sdo_oe_o)
		else $error("serial output driven with chip select high");
	chk_cfg_hold: assert property (
		cfg_quiet |=> $stable({pll_ctrl_o, ref_en_o, osc_div_o, osc_sel_o, div_bypass_o}))
		else $error("active settings changed without an update");
	chk_reload_done: assert property ($rose(resetn_i) |-> ##[1:40] !nvm_busy_o)
		else $error("reload after reset did not finish");
	chk_save_done: assert property ($rose(nvm_busy_o) |-> ##[1:40] !nvm_busy_o)
		else $error("store save did not finish");
endmodule

bind ccs_top ccs_top_sva u_sva (.clk_sys_i, .resetn_i, .spi_csn_i, .spi_sdo_oe_o, .pll_ctrl_o,
	.pll_run_o, .ref_en_o, .osc_div_o, .osc_sel_o, .div_bypass_o, .cal_start_o, .cal_busy_o,
	.nvm_busy_o);

// *** testbench.sv ***
// Purpose: Self-checking bench for the clock source configuration block.
// Assumes: Serial phases of several system clocks; store holds no image at time zero.
// Notes: Expected values come from the register map and reset defaults.
`timescale 1ns/100ps
module testbench;
	logic clk_sys_i; // System clock.
	logic resetn_i; // Active-low reset.
	logic sclk; // Serial clock, idles low.
	logic csn_n; // Serial chip select, active low.
	logic sdi; // Serial data toward the block.
	logic sdo, sdo_oe, pll_run, osc_sel, bypass, cal_start, cal_busy, nvm_busy;
	logic [7:0] pll_ctrl; // Active PLL control byte.
	logic [2:0] ref_en, osc_div;
	int n_fail, samples_checked, cycles, n_starts;

	ccs_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .spi_sclk_i(sclk),
		.spi_csn_i(csn_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
		.pll_ctrl_o(pll_ctrl), .pll_run_o(pll_run), .ref_en_o(ref_en), .osc_div_o(osc_div),
		.osc_sel_o(osc_sel), .div_bypass_o(bypass), .cal_start_o(cal_start),
		.cal_busy_o(cal_busy), .nvm_busy_o(nvm_busy));

	// Free-running 10 MHz clock.
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// Cuts a hang short and counts calibration start pulses.
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cal_start === 1'b1) n_starts <= n_starts + 1;
		if (cycles == 20000) begin
			n_fail++;
			results();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one byte-wide result.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One 24-bit frame; read data is sampled late in each low phase, once settled.
	task automatic xfer(input logic [23:0] frame, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge clk_sys_i) csn_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			@(posedge clk_sys_i) sclk <= 1'b0;
			sdi <= frame[i];
			repeat (5) @(posedge clk_sys_i);
			#1 if (i < 8) rd[i] = sdo;
			// The block must still be driving the data line at the last read bit.
			if (i == 0 && frame[23]) chk({7'h0, sdo_oe}, 8'h01, "sdo enable");
			@(posedge clk_sys_i) sclk <= 1'b1;
			repeat (3) @(posedge clk_sys_i);
		end
		@(posedge clk_sys_i) sclk <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		csn_n <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
	endtask

	// Register write and checked register read.
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer({3'h0, a, d}, r);
	endtask
	task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp, input string what);
		logic [7:0] r;
		xfer({3'h4, a, 8'h00}, r);
		chk(r, exp, what);
		chk({7'h0, sdo_oe}, 8'h00, "sdo release");
	endtask
	// Issues the update strobe and lets the active copy settle.
	task automatic upd();
		wr(ccs_pkg::OFS_UPDATE, 8'h01);
		repeat (4) @(posedge clk_sys_i);
	endtask

	// Resets the block and waits, bounded, for the store reload to end.
	task automatic do_reset();
		@(posedge clk_sys_i) resetn_i <= 1'b0;
		repeat (16) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 100 && nvm_busy !== 1'b0; i++) @(posedge clk_sys_i);
		chk({7'h0, nvm_busy}, 8'h00, "reload busy");
		// The last reloaded value reaches the outputs one edge after busy falls.
		repeat (2) @(posedge clk_sys_i);
	endtask

	// Checks every active output against one expected setting.
	task automatic cfg_chk(input logic [7:0] p, input logic [2:0] r, input logic [2:0] dv,
		input logic [1:0] route);
		chk(pll_ctrl, p, "pll_ctrl");
		chk({7'h0, pll_run}, {7'h0, p[1:0] == 2'h0}, "pll_run");
		chk({5'h0, ref_en}, {5'h0, r}, "ref_en");
		chk({5'h0, osc_div}, {5'h0, dv}, "osc_div");
		chk({6'h0, osc_sel, bypass}, {6'h0, route}, "route");
	endtask

	// Defaults after reset, at the outputs and in the registers.
	task automatic t_defaults();
		cfg_chk(8'h01, 3'h0, 3'h0, 2'h0);
		rd_chk(ccs_pkg::OFS_PLL, 8'h01, "pll reg");
		rd_chk(ccs_pkg::OFS_DIV, 8'h00, "div reg");
		rd_chk(ccs_pkg::OFS_ROUTE, 8'h00, "route reg");
		$display("test defaults done");
	endtask

	// Shadow writes stay hidden until the strobe; then three route settings.
	task automatic t_shadow();
		wr(ccs_pkg::OFS_PLL, 8'h00);
		wr(ccs_pkg::OFS_REF, 8'h05);
		wr(ccs_pkg::OFS_DIV, 8'h03);
		wr(ccs_pkg::OFS_ROUTE, 8'h03);
		cfg_chk(8'h01, 3'h0, 3'h0, 2'h0);
		rd_chk(ccs_pkg::OFS_ROUTE, 8'h03, "shadow route");
		rd_chk(13'h0100, 8'h00, "unmapped read");
		upd();
		cfg_chk(8'h00, 3'h5, 3'h3, 2'h3);
		rd_chk(ccs_pkg::OFS_UPDATE, 8'h00, "strobe cleared");
		wr(ccs_pkg::OFS_ROUTE, 8'h02);
		upd();
		cfg_chk(8'h00, 3'h5, 3'h3, 2'h2);
		wr(ccs_pkg::OFS_ROUTE, 8'h01);
		wr(ccs_pkg::OFS_REF, 8'h02);
		wr(ccs_pkg::OFS_DIV, 8'h05);
		upd();
		cfg_chk(8'h00, 3'h2, 3'h5, 2'h1);
		$display("test shadow done");
	endtask

	// Start, abort by clear, fresh start, and a strobe that must not restart.
	task automatic t_cal();
		int s0;
		s0 = n_starts;
		wr(ccs_pkg::OFS_CAL, 8'h01);
		upd();
		chk(8'(n_starts - s0), 8'h01, "first start");
		rd_chk(ccs_pkg::OFS_STATUS, 8'h01, "status busy");
		wr(ccs_pkg::OFS_CAL, 8'h00);
		upd();
		chk({7'h0, cal_busy}, 8'h00, "abort");
		wr(ccs_pkg::OFS_CAL, 8'h01);
		upd();
		chk(8'(n_starts - s0), 8'h02, "fresh start");
		for (int i = 0; i < 1200 && cal_busy !== 1'b0; i++) @(posedge clk_sys_i);
		chk({7'h0, cal_busy}, 8'h00, "cal done");
		upd();
		chk(8'(n_starts - s0), 8'h02, "no restart");
		$display("test calibration done");
	endtask

	// Saves the active settings and finds them again after a reset.
	task automatic t_nvm();
		wr(ccs_pkg::OFS_NVM_CTRL, 8'h01);
		for (int i = 0; i < 100 && nvm_busy !== 1'b0; i++) @(posedge clk_sys_i);
		do_reset();
		cfg_chk(8'h00, 3'h2, 3'h5, 2'h1);
		$display("test store done");
	endtask

	// Main sequence.
	initial begin
		resetn_i = 1'b0;
		sclk = 1'b0;
		csn_n = 1'b1;
		sdi = 1'b0;
		n_fail = 0;
		samples_checked = 0;
		cycles = 0;
		n_starts = 0;
		do_reset();
		t_defaults();
		t_shadow();
		t_cal();
		t_nvm();
		results();
	end
endmodule
